/* verilog/hrd_pkg.sv */
// Package for the receive deframer: register offsets, field layout, codes.
// Assumes an 8-bit register port with byte offsets and a 125 MHz system clock.
package hrd_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] REG_CTRL    = 8'h92;
  localparam logic [7:0] REG_STAT    = 8'h95;
  localparam logic [7:0] REG_DATA    = 8'h98;
  localparam logic [7:0] REG_IEN     = 8'h9b;
  localparam logic [7:0] REG_IFLAG   = 8'h9e;
  localparam logic [7:0] REG_HADDR   = 8'ha1;
  localparam logic [7:0] REG_LADDR   = 8'ha4;
  localparam logic [7:0] REG_ENABLE  = 8'h8b;
  // ==========================================================================
  // Field positions
  localparam int CTRL_MODE   = 0;
  localparam int CTRL_ADRM_LO = 1;
  localparam int CTRL_RST    = 3;
  localparam int ENA_BIT     = 0;
  localparam int STAT_OVH    = 0;
  localparam int STAT_EMPTY  = 1;
  localparam int IF_BLOCK    = 0;
  localparam int IF_OVFL     = 1;
  // ==========================================================================
  // Reset values and constants
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] FLAG_OCTET   = 8'h7e;
  localparam logic [6:0] ABORT_ONES   = 7'h7f;
  localparam logic [7:0] BCAST_A      = 8'hfc;
  localparam logic [7:0] BCAST_B      = 8'hfe;
  localparam logic [7:0] CR_MASK      = 8'hfd;
  localparam logic [15:0] CRC_INIT    = 16'hffff;
  localparam logic [15:0] CRC_POLY_R  = 16'h8408;
  localparam logic [15:0] CRC_GOOD    = 16'hf0b8;
  localparam int BLOCK_BYTES  = 32;
  localparam int FIFO_DEPTH   = 128;
  localparam int MIN_BYTES    = 5;
  localparam int STUFF_ONES   = 5;
  // Block type codes
  localparam logic [2:0] BT_SHORT_OK  = 3'h0;
  localparam logic [2:0] BT_MIDDLE    = 3'h1;
  localparam logic [2:0] BT_LAST_OK   = 3'h2;
  localparam logic [2:0] BT_SHORT_BAD = 3'h4;
  localparam logic [2:0] BT_LAST_BAD  = 3'h5;
  // Address match modes
  localparam logic [1:0] ADRM_NONE = 2'h0;
  localparam logic [1:0] ADRM_HIGH = 2'h1;
  localparam logic [1:0] ADRM_LOW  = 2'h2;
  localparam logic [1:0] ADRM_BOTH = 2'h3;
  typedef enum logic [1:0] {HRD_HUNT, HRD_DATA, HRD_CLOSE} hrd_state_type;
endpackage

/* verilog/hrd_deframer.sv */
// Receive deframer: flag hunt, destuff, CRC, address filter, blocks, FIFO.
// Assumes RX_BIT/RX_BIT_VALID come from same-clock framer logic.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module hrd_deframer
  import hrd_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic       RX_BIT,
  input  wire logic       RX_BIT_VALID,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  output logic            INT_N
);
  import hrd_pkg::*;

  // ==========================================================================
  // Registers
  logic [7:0] ctrl_q, ien_q, haddr_q, laddr_q;
  logic       enable_q;
  logic [1:0] iflag_q;
  logic       ovh_read_q;
  logic       rst_prev_q;
  logic       soft_rst;
  logic       wr_ctrl, rd_data;
  logic       blk_push_ev, ovfl_ev;

  assign wr_ctrl  = REG_WR && (REG_ADDR == REG_CTRL);
  assign rd_data  = REG_RD && (REG_ADDR == REG_DATA);
  assign soft_rst = wr_ctrl && REG_WDATA[CTRL_RST] && !rst_prev_q;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_q   <= CTRL_RESET;
      ien_q    <= 8'h00;
      haddr_q  <= 8'h00;
      laddr_q  <= 8'h00;
      enable_q <= 1'b0;
    end else if (REG_WR) begin
      if (REG_ADDR == REG_CTRL) begin
        ctrl_q <= REG_WDATA;
      end else if (REG_ADDR == REG_IEN) begin
        ien_q <= REG_WDATA;
      end else if (REG_ADDR == REG_HADDR) begin
        haddr_q <= REG_WDATA;
      end else if (REG_ADDR == REG_LADDR) begin
        laddr_q <= REG_WDATA;
      end else if (REG_ADDR == REG_ENABLE) begin
        enable_q <= REG_WDATA[ENA_BIT];
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rst_prev_q <= 1'b0;
    end else if (wr_ctrl) begin
      rst_prev_q <= REG_WDATA[CTRL_RST];
    end
  end

  // Interrupt flags: set wins over write-one clear
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      iflag_q <= 2'h0;
    end else begin
      if (REG_WR && (REG_ADDR == REG_IFLAG)) begin
        iflag_q <= iflag_q & ~REG_WDATA[1:0];
      end
      if (blk_push_ev) begin
        iflag_q[IF_BLOCK] <= 1'b1;
      end
      if (ovfl_ev) begin
        iflag_q[IF_OVFL] <= 1'b1;
      end
    end
  end

  assign INT_N = !(|(iflag_q & ien_q[1:0]));

  // ==========================================================================
  // FIFO
  logic [7:0] fifo_mem [FIFO_DEPTH];
  logic       fifo_ovh [FIFO_DEPTH];
  logic [6:0] wp_q, rp_q;
  logic [7:0] cnt_q;
  logic       push, push_ovh, pop, full, empty;
  logic [7:0] push_data;
  logic [7:0] blocks_q;

  assign full  = (cnt_q == 8'(FIFO_DEPTH));
  assign empty = (cnt_q == 8'h00);
  assign pop   = rd_data && !empty;
  assign ovfl_ev = push && full;

  always_ff @(posedge CLK) begin
    if (push && !full) begin
      fifo_mem[wp_q] <= push_data;
      fifo_ovh[wp_q] <= push_ovh;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST || soft_rst) begin
      wp_q  <= 7'h00;
      rp_q  <= 7'h00;
      cnt_q <= 8'h00;
    end else begin
      if (push && !full) begin
        wp_q <= wp_q + 7'h01;
      end
      if (pop) begin
        rp_q <= rp_q + 7'h01;
      end
      cnt_q <= cnt_q + 8'((push && !full) ? 1 : 0) - 8'(pop ? 1 : 0);
    end
  end

  // Block counter: counts overheads in FIFO, for the empty flag
  always_ff @(posedge CLK) begin
    if (SYS_RST || soft_rst) begin
      blocks_q <= 8'h00;
    end else begin
      blocks_q <= blocks_q + 8'((push && push_ovh && !full) ? 1 : 0)
                           - 8'((pop && fifo_ovh[rp_q]) ? 1 : 0);
    end
  end

  // ==========================================================================
  // Read data
  always_ff @(posedge CLK) begin
    if (SYS_RST || soft_rst) begin
      ovh_read_q <= 1'b0;
    end else if (pop) begin
      ovh_read_q <= fifo_ovh[rp_q];
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      if (REG_ADDR == REG_CTRL) begin
        REG_RDATA <= ctrl_q;
      end else if (REG_ADDR == REG_STAT) begin
        REG_RDATA <= {6'h00, (blocks_q == 8'h00) && empty, ovh_read_q};
      end else if (REG_ADDR == REG_DATA) begin
        REG_RDATA <= empty ? 8'h00 : fifo_mem[rp_q];
      end else if (REG_ADDR == REG_IEN) begin
        REG_RDATA <= ien_q;
      end else if (REG_ADDR == REG_IFLAG) begin
        REG_RDATA <= {6'h00, iflag_q};
      end else if (REG_ADDR == REG_HADDR) begin
        REG_RDATA <= haddr_q;
      end else if (REG_ADDR == REG_LADDR) begin
        REG_RDATA <= laddr_q;
      end else if (REG_ADDR == REG_ENABLE) begin
        REG_RDATA <= {7'h00, enable_q};
      end else begin
        REG_RDATA <= 8'h00;
      end
    end
  end

  // ==========================================================================
  // Bit level: flag, abort, destuff
  logic       active;
  logic [7:0] shreg_q;
  logic [2:0] ones_q;
  logic [7:0] shift_n;
  logic       is_flag, is_abort, is_stuff, data_bit;
  logic       raw_bit, dbit;
  logic [6:0] pend_q;
  logic [2:0] pend_n_q;
  hrd_state_type st_q;

  assign active   = enable_q && !ctrl_q[CTRL_MODE] && RX_BIT_VALID;
  assign shift_n  = {RX_BIT, shreg_q[7:1]};
  assign is_flag  = (shift_n == FLAG_OCTET);
  assign is_abort = RX_BIT && (ones_q == 3'd6) && (shift_n[7:1] == ABORT_ONES);
  assign is_stuff = !RX_BIT && (ones_q == 3'(STUFF_ONES));
  assign raw_bit  = active && (st_q == HRD_DATA) && !is_flag && !is_abort && !is_stuff;
  // Seven bits held back, so the head of a closing flag never reaches a byte
  assign data_bit = raw_bit && (pend_n_q == 3'h7);
  assign dbit     = pend_q[0];

  always_ff @(posedge CLK) begin
    if (SYS_RST || soft_rst) begin
      shreg_q <= 8'h00;
      ones_q  <= 3'h0;
    end else if (active) begin
      shreg_q <= shift_n;
      ones_q  <= RX_BIT ? ((ones_q == 3'd7) ? ones_q : ones_q + 3'h1) : 3'h0;
    end
  end

  // Delay line of destuffed bits; a flag drops the bits it holds
  always_ff @(posedge CLK) begin
    if (SYS_RST || soft_rst || (active && is_flag)) begin
      pend_n_q <= 3'h0;
    end else if (raw_bit) begin
      pend_q <= {RX_BIT, pend_q[6:1]};
      if (pend_n_q != 3'h7) begin
        pend_n_q <= pend_n_q + 3'h1;
      end
    end
  end

  // ==========================================================================
  // Byte assembly, CRC, delay line holding the last two bytes
  logic [7:0]  byte_q, d1_q, d2_q;
  logic [2:0]  bitc_q;
  logic [15:0] crc_q;
  logic [1:0]  held_q;
  logic [7:0]  nbytes_q;
  logic        byte_done, out_byte, bad_q, end_frame, crc_fb;
  logic [7:0]  assembled;

  assign assembled = {dbit, byte_q[7:1]};
  assign byte_done = data_bit && (bitc_q == 3'h7);
  assign out_byte  = byte_done && (held_q == 2'h2); // byte leaving FCS window
  assign crc_fb    = crc_q[0] ^ dbit;

  always_ff @(posedge CLK) begin
    if (SYS_RST || soft_rst || (active && is_flag)) begin
      bitc_q <= 3'h0;
      crc_q  <= CRC_INIT;
      held_q <= 2'h0;
    end else if (data_bit) begin
      byte_q <= assembled;
      bitc_q <= bitc_q + 3'h1;
      crc_q  <= (crc_q >> 1) ^ (crc_fb ? CRC_POLY_R : 16'h0000);
      if (byte_done) begin
        d1_q <= assembled;
        d2_q <= d1_q;
        if (held_q != 2'h2) begin
          held_q <= held_q + 2'h1;
        end
      end
    end
  end

  // ==========================================================================
  // Frame state
  always_ff @(posedge CLK) begin
    if (SYS_RST || soft_rst) begin
      st_q <= HRD_HUNT;
    end else if (active) begin
      case (st_q)
        HRD_HUNT: begin
          if (is_flag) begin
            st_q <= HRD_DATA;
          end
        end
        HRD_DATA: begin
          if (is_abort) begin
            st_q <= HRD_HUNT;
          end
        end
        default: st_q <= HRD_HUNT;
      endcase
    end
  end

  assign end_frame = active && (st_q == HRD_DATA) && (is_flag || is_abort);

  // ==========================================================================
  // Address check and block building
  logic [5:0] blk_cnt_q;
  logic [7:0] blk_buf [BLOCK_BYTES];
  logic       long_q;
  logic       addr_bad;
  logic [1:0] adrm;
  logic       hi_ok, lo_ok, bad_now, frame_bad, empty_frame;
  logic       flush_q;
  logic [5:0] flush_n_q, flush_i_q;
  logic [2:0] flush_t_q;
  logic       blk_full;

  assign adrm  = ctrl_q[CTRL_ADRM_LO+1:CTRL_ADRM_LO];
  assign hi_ok = ((d2_q & CR_MASK) == (haddr_q & CR_MASK)) || ((d2_q & CR_MASK) == BCAST_A)
                 || ((d2_q & CR_MASK) == (BCAST_B & CR_MASK));
  assign lo_ok = (d2_q == laddr_q);
  always_comb begin
    addr_bad = 1'b0;
    if (out_byte && (nbytes_q == 8'h00)) begin
      if (adrm == ADRM_HIGH || adrm == ADRM_BOTH) begin
        addr_bad = !hi_ok;
      end else if (adrm == ADRM_LOW) begin
        addr_bad = !lo_ok;
      end
    end else if (out_byte && (nbytes_q == 8'h01) && (adrm == ADRM_BOTH)) begin
      addr_bad = !lo_ok;
    end
  end

  assign empty_frame = (held_q == 2'h0) && (nbytes_q == 8'h00) && (bitc_q == 3'h0);
  assign frame_bad = is_abort
                  || (bitc_q != 3'h0)
                  || ((nbytes_q + 8'(held_q)) < 8'(MIN_BYTES))
                  || (crc_q != CRC_GOOD)
                  || bad_q || addr_bad;
  assign bad_now  = bad_q || addr_bad;
  assign blk_full = out_byte && !bad_now && (blk_cnt_q == 6'(BLOCK_BYTES - 1));

  always_ff @(posedge CLK) begin
    if (SYS_RST || soft_rst || (active && is_flag && st_q != HRD_DATA)) begin
      nbytes_q <= 8'h00;
      bad_q    <= 1'b0;
      long_q   <= 1'b0;
      blk_cnt_q <= 6'h00;
    end else if (end_frame) begin
      nbytes_q <= 8'h00;
      bad_q    <= 1'b0;
      long_q   <= 1'b0;
      blk_cnt_q <= 6'h00;
    end else if (out_byte) begin
      nbytes_q <= (nbytes_q == 8'hff) ? nbytes_q : nbytes_q + 8'h01;
      bad_q    <= bad_now;
      if (!bad_now) begin
        blk_buf[blk_cnt_q[4:0]] <= d2_q;
        blk_cnt_q <= blk_full ? 6'h00 : blk_cnt_q + 6'h01;
        if (blk_full) begin
          long_q <= 1'b1;
        end
      end
    end
  end

  // Flush a finished block: overhead first, then its data bytes
  always_ff @(posedge CLK) begin
    if (SYS_RST || soft_rst) begin
      flush_q   <= 1'b0;
      flush_n_q <= 6'h00;
      flush_i_q <= 6'h00;
      flush_t_q <= BT_SHORT_OK;
    end else if (blk_full) begin
      flush_q   <= 1'b1;
      flush_n_q <= 6'(BLOCK_BYTES);
      flush_i_q <= 6'h00;
      flush_t_q <= BT_MIDDLE;
    end else if (end_frame && !empty_frame) begin
      flush_q   <= 1'b1;
      flush_n_q <= frame_bad ? 6'h00 : blk_cnt_q;
      flush_i_q <= 6'h00;
      flush_t_q <= frame_bad ? (long_q ? BT_LAST_BAD : BT_SHORT_BAD)
                             : (long_q ? BT_LAST_OK : BT_SHORT_OK);
    end else if (flush_q) begin
      flush_i_q <= flush_i_q + 6'h01;
      if (flush_i_q == flush_n_q) begin
        flush_q <= 1'b0;
      end
    end
  end

  // Blocks of 32 overlap the next block fill; the flush runs 33 cycles per 256 bit slots
  assign push      = flush_q;
  assign push_ovh  = flush_q && (flush_i_q == 6'h00);
  assign push_data = push_ovh ? {flush_t_q, flush_t_q[2] ? 5'h00
                                 : 5'(flush_n_q - 6'h01)}
                              : blk_buf[5'(flush_i_q - 6'h01)];
  assign blk_push_ev = push_ovh && !full;

endmodule // hrd_deframer

/* sim/hrd_deframer_monitor.sv */
// Checker for the deframer register port and interrupt pin.
// Assumes it is bound to hrd_deframer and sees only its ports.
`timescale 1ns/1ps
module hrd_deframer_monitor
  import hrd_pkg::*;
(
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       RX_BIT,
  input wire logic       RX_BIT_VALID,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic       INT_N
);
  logic mapped;
  logic rst_bit_q;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  assign mapped = REG_ADDR inside {REG_CTRL, REG_STAT, REG_DATA, REG_IEN, REG_IFLAG,
                                   REG_HADDR, REG_LADDR, REG_ENABLE};
  // Last written soft reset bit, to spot a zero-to-one write
  always_ff @(posedge CLK) begin
    if (SYS_RST) rst_bit_q <= 1'b0;
    else if (REG_WR && REG_ADDR == REG_CTRL) rst_bit_q <= REG_WDATA[CTRL_RST];
  end
  // ==========================================================================
  // Properties
  sequence s_wr(logic [7:0] a);
    REG_WR && REG_ADDR == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    REG_RD && REG_ADDR == a;
  endsequence
  sequence s_soft;
    REG_WR && REG_ADDR == REG_CTRL && REG_WDATA[CTRL_RST] && !rst_bit_q;
  endsequence
  property p_rb(logic [7:0] a, logic [7:0] m);
    s_wr(a) ##1 s_rd(a) |=> (REG_RDATA & m) == ($past(REG_WDATA, 2) & m);
  endproperty
  reset_vals_a: assert property ($fell(SYS_RST) |-> REG_RDATA == 8'h00 && INT_N)
    else $error("read data or interrupt not idle after reset");
  rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data changed without a read");
  unmapped_zero_a: assert property (REG_RD && !mapped |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  rb_high_a: assert property (p_rb(REG_HADDR, 8'hff))
    else $error("high address readback wrong");
  rb_low_a: assert property (p_rb(REG_LADDR, 8'hff))
    else $error("low address readback wrong");
  rb_ien_a: assert property (p_rb(REG_IEN, 8'h03))
    else $error("interrupt enable readback wrong");
  rb_ctrl_a: assert property (p_rb(REG_CTRL, 8'h07))
    else $error("control readback wrong");
  int_mask_a: assert property (REG_WR && REG_ADDR == REG_IEN && REG_WDATA[1:0] == 2'h0 |=> INT_N)
    else $error("interrupt pin low with all enables off");
  soft_rst_a: assert property (s_soft ##1 s_rd(REG_DATA) |=> REG_RDATA == 8'h00)
    else $error("data left after soft reset");
  stat_clear_a: assert property (s_soft ##1 s_rd(REG_STAT) |=> !REG_RDATA[STAT_OVH])
    else $error("overhead status kept after soft reset");
endmodule // hrd_deframer_monitor

/* sim/hrd_bit_source.sv */
// Framer-side model: sends flagged, stuffed frames with a CRC trailer.
// Assumes the deframer samples RX_BIT while RX_BIT_VALID is high.
`timescale 1ns/1ps
module hrd_bit_source
  import hrd_pkg::*;
#(
  parameter int GAP = 40
) (
  input  wire logic CLK,
  output logic      RX_BIT,
  output logic      RX_BIT_VALID
);
  int ones;
  initial begin
    RX_BIT = 1'b0;
    RX_BIT_VALID = 1'b0;
    ones = 0;
  end
  // ==========================================================================
  // One bit per GAP cycles; the line holds the inverted bit while no bit is offered
  task automatic put_bit(input logic b);
    @(posedge CLK);
    RX_BIT <= b;
    RX_BIT_VALID <= 1'b1;
    @(posedge CLK);
    RX_BIT <= ~b;
    RX_BIT_VALID <= 1'b0;
    repeat (GAP - 2) @(posedge CLK);
    ones = b ? ones + 1 : 0;
  endtask
  task automatic put_byte(input logic [7:0] v, input bit st);
    for (int i = 0; i < 8; i++) begin
      put_bit(v[i]);
      if (st && ones == STUFF_ONES) put_bit(1'b0);
    end
  endtask
  // Kind: 0 good, 1 bad check sequence, 2 abort, 3 stray bits
  task automatic send_frame(input logic [7:0] q[$], input int kind);
    logic [15:0] crc;
    crc = CRC_INIT;
    put_byte(FLAG_OCTET, 1'b0);
    ones = 0;
    foreach (q[j]) begin
      put_byte(q[j], 1'b1);
      for (int i = 0; i < 8; i++)
        crc = (crc >> 1) ^ ((crc[0] ^ q[j][i]) ? CRC_POLY_R : 16'h0000);
    end
    if (kind == 2) put_byte(8'hff, 1'b0);
    else begin
      if (kind == 3) repeat (3) put_bit(1'b0);
      crc = ~crc ^ ((kind == 1) ? 16'h0001 : 16'h0000);
      put_byte(crc[7:0], 1'b1);
      put_byte(crc[15:8], 1'b1);
    end
    put_byte(FLAG_OCTET, 1'b0);
  endtask
endmodule // hrd_bit_source

/* sim/tb_hrd_deframer.sv */
// Self-checking bench for the receive deframer.
// Assumes hrd_pkg, the deframer, the bit source and the checker are compiled.
`timescale 1ns/1ps
module tb_hrd_deframer;
  import hrd_pkg::*;
  typedef struct {logic [1:0] adrm; logic [7:0] b0; logic [7:0] b1; int len; int kind;
                  bit ok;} hrd_row_type;
  logic       CLK = 1'b0;
  logic       SYS_RST, RX_BIT, RX_BIT_VALID, REG_WR, REG_RD, INT_N;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, v;
  logic [7:0] d[$];
  int         num_errors, n_checks;
  hrd_row_type rows [12] = '{
    '{ADRM_NONE, 8'h11, 8'h22, 3, 0, 1'b1},
    '{ADRM_NONE, 8'h11, 8'h22, 2, 0, 1'b0},
    '{ADRM_NONE, 8'h11, 8'h22, 4, 1, 1'b0},
    '{ADRM_NONE, 8'h11, 8'h22, 4, 2, 1'b0},
    '{ADRM_NONE, 8'h11, 8'h22, 4, 3, 1'b0},
    '{ADRM_NONE, 8'h11, 8'h22, 33, 0, 1'b1},
    '{ADRM_NONE, 8'h11, 8'h22, 33, 1, 1'b0},
    '{ADRM_HIGH, 8'h32, 8'h22, 3, 0, 1'b1},
    '{ADRM_HIGH, 8'h44, 8'h22, 3, 0, 1'b0},
    '{ADRM_LOW,  8'h53, 8'h22, 3, 0, 1'b0},
    '{ADRM_BOTH, 8'hfe, 8'h51, 3, 0, 1'b1},
    '{ADRM_BOTH, 8'h30, 8'h50, 3, 0, 1'b0}
  };
  always #4 CLK = ~CLK;
  hrd_deframer i_dut (.CLK, .SYS_RST, .RX_BIT, .RX_BIT_VALID, .REG_ADDR, .REG_WDATA,
                      .REG_WR, .REG_RD, .REG_RDATA, .INT_N);
  hrd_bit_source #(.GAP(16)) i_src (.CLK, .RX_BIT, .RX_BIT_VALID);
  // ==========================================================================
  // Register port tasks and checks
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= w;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(posedge CLK);
    q = REG_RDATA;
  endtask
  // Write then read in the very next cycle
  task automatic bb(input logic [7:0] wa, input logic [7:0] w, input logic [7:0] ra,
                    output logic [7:0] q);
    @(posedge CLK);
    REG_ADDR <= wa;
    REG_WDATA <= w;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
    REG_ADDR <= ra;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(posedge CLK);
    q = REG_RDATA;
  endtask
  task automatic pop(input logic [7:0] e, input logic ovh);
    rd(REG_DATA, v);
    chk(v, e);
    rd(REG_STAT, v);
    chk(v[STAT_OVH], ovh);
  endtask
  task automatic mk(input hrd_row_type rw);
    d = {};
    for (int i = 0; i < rw.len; i++)
      d.push_back(i == 0 ? rw.b0 : i == 1 ? rw.b1 : (i % 3 == 0) ? 8'hff : 8'(i));
  endtask
  task automatic drain(input bit ok, input int len);
    int k;
    int n;
    k = 0;
    while (len - k > 32) begin
      pop({BT_MIDDLE, 5'h1f}, 1'b1);
      for (n = 0; n < 32; n++) pop(d[k + n], 1'b0);
      k += 32;
    end
    n = len - k;
    if (ok) begin
      pop({(len > 32) ? BT_LAST_OK : BT_SHORT_OK, 5'(n - 1)}, 1'b1);
      for (int i = 0; i < n; i++) pop(d[k + i], 1'b0);
    end else pop({(len > 32) ? BT_LAST_BAD : BT_SHORT_BAD, 5'h00}, 1'b1);
    rd(REG_STAT, v);
    chk(v[STAT_EMPTY], 1'b1);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge CLK);
    num_errors++;
    stop_test;
  end
  // ==========================================================================
  // Main sequence
  initial begin
    SYS_RST = 1'b1;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    num_errors = 0;
    n_checks = 0;
    repeat (3) @(posedge CLK);
    SYS_RST <= 1'b0;
    rd(REG_CTRL, v);
    chk(v, CTRL_RESET);
    chk(INT_N, 1'b1);
    rd(8'h00, v);
    chk(v, 8'h00);
    mk(rows[0]);
    i_src.send_frame(d, 0);
    repeat (40) @(posedge CLK);
    rd(REG_DATA, v);
    chk(v, 8'h00);
    $display("test reset_disabled done");
    wr(REG_ENABLE, 8'h01);
    bb(REG_HADDR, 8'h30, REG_HADDR, v);
    chk(v, 8'h30);
    bb(REG_LADDR, 8'h51, REG_LADDR, v);
    chk(v, 8'h51);
    foreach (rows[r]) begin
      bb(REG_CTRL, {5'h00, rows[r].adrm, 1'b0}, REG_CTRL, v);
      chk(v, {5'h00, rows[r].adrm, 1'b0});
      mk(rows[r]);
      i_src.send_frame(d, rows[r].kind);
      repeat (40) @(posedge CLK);
      drain(rows[r].ok, rows[r].len);
    end
    $display("test frame_table done");
    bb(REG_CTRL, 8'h00, REG_CTRL, v);
    wr(REG_IFLAG, 8'h03);
    bb(REG_IEN, 8'h03, REG_IEN, v);
    chk(v[1:0], 2'h3);
    mk('{ADRM_NONE, 8'h01, 8'h02, 33, 0, 1'b1});
    repeat (3) i_src.send_frame(d, 0);
    mk('{ADRM_NONE, 8'h01, 8'h02, 23, 0, 1'b1});
    i_src.send_frame(d, 0);
    repeat (40) @(posedge CLK);
    rd(REG_IFLAG, v);
    chk(v[1:0], 2'h3);
    chk(INT_N, 1'b0);
    bb(REG_IEN, 8'h00, REG_IFLAG, v);
    chk(INT_N, 1'b1);
    wr(REG_IEN, 8'h03);
    wr(REG_IFLAG, 8'h03);
    rd(REG_IFLAG, v);
    chk(v[1:0], 2'h0);
    $display("test irq_overflow done");
    bb(REG_CTRL, 8'h08, REG_DATA, v);
    chk(v, 8'h00);
    wr(REG_CTRL, 8'h00);
    mk(rows[0]);
    i_src.send_frame(d, 0);
    repeat (40) @(posedge CLK);
    pop({BT_SHORT_OK, 5'h02}, 1'b1);
    bb(REG_CTRL, 8'h08, REG_STAT, v);
    chk(v[STAT_OVH], 1'b0);
    rd(REG_DATA, v);
    chk(v, 8'h00);
    $display("test soft_reset done");
    stop_test;
  end
endmodule // tb_hrd_deframer

bind hrd_deframer hrd_deframer_monitor i_mon (.CLK, .SYS_RST, .RX_BIT, .RX_BIT_VALID,
  .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .INT_N);
